// ==== verilog/fcf_pkg.sv ====
package fcf_pkg;

  localparam int DATA_W    = 18;
  localparam int OFS_W     = 12;
  localparam int DEPTH_256 = 256;
  localparam int DEPTH_512 = 512;
  localparam int DEPTH_1K  = 1024;
  localparam int DEPTH_2K  = 2048;
  localparam int DEPTH_4K  = 4096;

  // Offsets loaded at reset, per array size
  localparam logic [OFS_W-1:0] OFS_DEF_256 = 12'h01F;
  localparam logic [OFS_W-1:0] OFS_DEF_512 = 12'h03F;
  localparam logic [OFS_W-1:0] OFS_DEF_BIG = 12'h07F;

  typedef enum logic [0:0] {
    FCF_SEL_AE = 1'b0,
    FCF_SEL_AF = 1'b1
  } fcf_ofs_sel_t;

  function automatic logic [OFS_W-1:0] fcf_default_offset(input int depth);
    if (depth == DEPTH_256) begin
      return OFS_DEF_256;
    end else if (depth == DEPTH_512) begin
      return OFS_DEF_512;
    end
    return OFS_DEF_BIG;
  endfunction

endpackage

// ==== verilog/fcf_ram.sv ====
module fcf_ram #(
  parameter int DEPTH  = 1024,
  parameter int ADDR_W = 10
) (
  input  wire logic                       sys_clk,
  input  wire logic                       wrEn,
  input  wire logic [ADDR_W-1:0]          wrAddr,
  input  wire logic [fcf_pkg::DATA_W-1:0] wrWord,
  input  wire logic [ADDR_W-1:0]          rdAddr,
  output logic      [fcf_pkg::DATA_W-1:0] rdWord
);
  import fcf_pkg::*;

  logic [DATA_W-1:0] mem [DEPTH];

  // Array holds contents across reset; pointers, count and output register are cleared, flags and offsets take their reset values
  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrWord;
    end
  end

  // Unregistered read so the head word reaches the output register at once
  assign rdWord = mem[rdAddr];

endmodule

// ==== verilog/fcf_offset_regs.sv ====
module fcf_offset_regs #(
  parameter int DEPTH = 1024
) (
  input  wire logic                      sys_clk,
  input  wire logic                      srst,
  input  wire logic                      wrLoad,
  input  wire logic                      rdLoad,
  input  wire logic [fcf_pkg::OFS_W-1:0] wrBits,
  output logic      [fcf_pkg::OFS_W-1:0] aeOffset,
  output logic      [fcf_pkg::OFS_W-1:0] afOffset,
  output logic      [fcf_pkg::OFS_W-1:0] rdBits
);
  import fcf_pkg::*;

  fcf_ofs_sel_t sel;
  fcf_ofs_sel_t next_sel;
  wire          step = wrLoad | rdLoad;

  // Shared sequencer: a read and a write in one cycle step only once
  always_comb begin
    next_sel = sel;
    if (step) begin
      unique case (sel)
        FCF_SEL_AE: next_sel = FCF_SEL_AF; // see R24
        FCF_SEL_AF: next_sel = FCF_SEL_AE; // see R24
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sel <= FCF_SEL_AE;
    end else begin
      sel <= next_sel; // see R14
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      aeOffset <= fcf_default_offset(DEPTH); // see R21
      afOffset <= fcf_default_offset(DEPTH); // see R21
    end else if (wrLoad && sel == FCF_SEL_AE) begin
      aeOffset <= wrBits; // see R12
    end else if (wrLoad && sel == FCF_SEL_AF) begin
      afOffset <= wrBits; // see R12
    end
  end

  // Readback shows the register selected before this access steps on
  assign rdBits = (sel == FCF_SEL_AE) ? aeOffset : afOffset;

endmodule

// ==== verilog/fcf_top.sv ====
// Function
// R1 - Stores one 18-bit input word per write, 18-bit output port.
// R2 - Depth is a build parameter: 256, 512, 1024, 2048 or 4096 words.
// R3 - Read and write share one clock here, coincident operation.
// R4 - Write enable low with load high stores input word; high holds.
// R5 - Writes while full are ignored; pointer does not move.
// R6 - Read enable low with load high advances pointer, shows next word.
// R7 - Read enable high keeps the output register unchanged.
// R8 - Reads while empty are ignored; pointer and output hold.
// R9 - Output enable low drives output bus; high floats it.
// R10 - Reset clears pointers, full and almost-full high, others low; code also resets half-full and read-chain outputs high.
// R11 - Outside logic resets the block before its first write.
// R12 - Load low with write enable low writes offset bits 0..11.
// R13 - Load low with read enable low reads offset onto bits 0..11.
// R14 - Small state machine sequences offset loading under load pin.
// R15 - Full flag low when array full, updated on write clock.
// R16 - Half-full function only when not in a depth chain.
// R17 - First-load input tied low single; chain: low first, high others.
// R18 - Write chain input tied low single; chain: previous write output.
// R19 - Read chain input tied low single; chain: previous read output.
// R20 - Empty flag low when no words remain, updated on read clock.
// R21 - Offsets default 31, 63 or 127 by depth; flags low within.
// R22 - Shared output is half-full single, last-write pulse in chain.
// R23 - In chain, read output pulses when the last location is read.
// R24 - Offset accesses alternate almost-empty then almost-full, wrapping.
// R25 - Word written to empty array shows on output with no dummy read.
module fcf_top #(
  parameter int DEPTH = 1024
) (
  input  wire logic                       sys_clk,
  input  wire logic                       srst,
  input  wire logic [fcf_pkg::DATA_W-1:0] wrData,
  input  wire logic                       wrEnN,
  input  wire logic                       rdEnN,
  input  wire logic                       outEnN,
  input  wire logic                       offsetLoadN,
  input  wire logic                       chainEnable,
  input  wire logic                       chainFirstN,
  input  wire logic                       wrChainInN,
  input  wire logic                       rdChainInN,
  output logic      [fcf_pkg::DATA_W-1:0] rdData,
  output logic                            rdDataOe,
  output logic                            fullN,
  output logic                            emptyN,
  output logic                            almostEmptyN,
  output logic                            almostFullN,
  output logic                            halfFullN,
  output logic                            rdChainOutN
);
  import fcf_pkg::*;

  localparam int ADDR_W = $clog2(DEPTH);
  localparam int CNT_W  = ADDR_W + 1;
  localparam logic [CNT_W-1:0]  CNT_FULL = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0]  CNT_HALF = CNT_W'(DEPTH / 2);
  localparam logic [CNT_W-1:0]  CNT_ZERO = '0;
  localparam logic [CNT_W-1:0]  CNT_ONE  = CNT_W'(1);
  localparam logic [ADDR_W-1:0] PTR_ZERO = '0;
  localparam logic [ADDR_W-1:0] PTR_ONE  = ADDR_W'(1);
  localparam logic [ADDR_W-1:0] PTR_LAST = ADDR_W'(DEPTH - 1);
  localparam int PAD_W = DATA_W - OFS_W;
  localparam int CMP_W = CNT_W + OFS_W;

  function automatic logic [ADDR_W-1:0] ptr_inc(input logic [ADDR_W-1:0] p);
    return ADDR_W'(p + PTR_ONE);
  endfunction

  function automatic logic [CMP_W-1:0] ofs_count(input logic [OFS_W-1:0] o);
    return CMP_W'(o);
  endfunction

  // Unsupported depths stop elaboration rather than silently misbehave
  if (DEPTH != DEPTH_256 && DEPTH != DEPTH_512 && DEPTH != DEPTH_1K &&
      DEPTH != DEPTH_2K && DEPTH != DEPTH_4K) begin : g_bad_depth
    $error("unsupported depth"); // see R2
  end

  logic [ADDR_W-1:0] wrPtr;
  logic [ADDR_W-1:0] rdPtr;
  logic [CNT_W-1:0]  count;
  logic [CNT_W-1:0]  next_count;
  logic              chainMode;
  logic              wrToken;
  logic              rdToken;
  logic [DATA_W-1:0] next_rdData;
  logic [DATA_W-1:0] headWord;
  logic [OFS_W-1:0]  aeOffset;
  logic [OFS_W-1:0]  afOffset;
  logic [OFS_W-1:0]  ofsRdBits;

  wire isFull  = (count == CNT_FULL);
  wire isEmpty = (count == CNT_ZERO);

  // Accepted accesses; the load pin diverts both ports to offsets
  wire wrAcc  = ~wrEnN & offsetLoadN & ~isFull & wrToken;   // see R4 R5
  wire rdAcc  = ~rdEnN & offsetLoadN & ~isEmpty & rdToken;  // see R6 R8
  wire wrLoad = ~wrEnN & ~offsetLoadN;                      // see R12
  wire rdLoad = ~rdEnN & ~offsetLoadN;                      // see R13

  wire wrLast = wrAcc & (wrPtr == PTR_LAST);
  wire rdLast = rdAcc & (rdPtr == PTR_LAST);

  wire [ADDR_W-1:0] headAddr = ptr_inc(rdPtr);

  // Compared wide so offsets above the depth are never cut short
  wire [CMP_W-1:0] levelW = CMP_W'(next_count);
  wire [CMP_W-1:0] fullW  = CMP_W'(CNT_FULL);
  wire [CMP_W-1:0] afSum  = CMP_W'(levelW + ofs_count(afOffset));

  wire next_fullN   = (next_count != CNT_FULL);                 // see R15
  wire next_emptyN  = (next_count != CNT_ZERO);                 // see R20
  wire next_aeN     = (levelW > ofs_count(aeOffset));           // see R21
  wire next_afN     = (afSum < fullW);                          // see R21
  wire next_halfN   = chainMode ? ~wrLast                       // see R22
                                : (next_count <= CNT_HALF);     // see R16
  wire next_rdChain = ~(chainMode & rdLast);                    // see R23

  fcf_ram #(
    .DEPTH  (DEPTH),
    .ADDR_W (ADDR_W)
  ) u_ram (
    .sys_clk (sys_clk),
    .wrEn    (wrAcc),
    .wrAddr  (wrPtr),
    .wrWord  (wrData),
    .rdAddr  (headAddr),
    .rdWord  (headWord)
  );

  fcf_offset_regs #(
    .DEPTH (DEPTH)
  ) u_ofs (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .wrLoad   (wrLoad),
    .rdLoad   (rdLoad),
    .wrBits   (wrData[OFS_W-1:0]),
    .aeOffset (aeOffset),
    .afOffset (afOffset),
    .rdBits   (ofsRdBits)
  );

  always_comb begin
    next_count = count;
    if (wrAcc && !rdAcc) begin
      next_count = CNT_W'(count + CNT_ONE);
    end else if (rdAcc && !wrAcc) begin
      next_count = CNT_W'(count - CNT_ONE);
    end
  end

  // Output register: offset readback, read advance or fall-through
  always_comb begin
    next_rdData = rdData; // see R7
    if (rdLoad) begin
      next_rdData = {{PAD_W{1'b0}}, ofsRdBits}; // see R13
    end else if (rdAcc) begin
      if (count > CNT_ONE) begin
        next_rdData = headWord; // see R6
      end else if (wrAcc) begin
        next_rdData = wrData;
      end
    end else if (isEmpty && wrAcc) begin
      next_rdData = wrData; // see R25
    end
  end

  // Chain role is strapped while reset is held
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      chainMode <= chainEnable; // see R17
    end
  end

  // Single device always owns both ports; a chain passes them along
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wrToken <= ~chainEnable | ~chainFirstN;
    end else if (chainMode && wrLast) begin
      wrToken <= 1'b0;
    end else if (chainMode && !wrChainInN) begin
      wrToken <= 1'b1; // see R18
    end else if (!chainMode) begin
      wrToken <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdToken <= ~chainEnable | ~chainFirstN;
    end else if (chainMode && rdLast) begin
      rdToken <= 1'b0;
    end else if (chainMode && !rdChainInN) begin
      rdToken <= 1'b1; // see R19
    end else if (!chainMode) begin
      rdToken <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wrPtr <= PTR_ZERO; // see R10
      rdPtr <= PTR_ZERO; // see R10
      count <= CNT_ZERO;
    end else begin
      if (wrAcc) begin
        wrPtr <= ptr_inc(wrPtr); // see R4
      end
      if (rdAcc) begin
        rdPtr <= ptr_inc(rdPtr); // see R6
      end
      count <= next_count; // see R3
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      fullN        <= 1'b1; // see R10
      almostFullN  <= 1'b1; // see R10
      emptyN       <= 1'b0; // see R10
      almostEmptyN <= 1'b0; // see R10
      halfFullN    <= 1'b1;
      rdChainOutN  <= 1'b1;
    end else begin
      fullN        <= next_fullN;
      almostFullN  <= next_afN;
      emptyN       <= next_emptyN;
      almostEmptyN <= next_aeN;
      halfFullN    <= next_halfN;
      rdChainOutN  <= next_rdChain;
    end
  end

  // Contents kept through reset; the port view is cleared along with pointers and count
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdData <= '0;
    end else begin
      rdData <= next_rdData; // see R1
    end
  end

  // Tri-state is resolved outside; this only says when to drive
  assign rdDataOe = ~outEnN; // see R9

  default clocking cb @(posedge sys_clk);
  endclocking

  default disable iff (srst);

  property p_fullBlocks;
    !fullN && !wrEnN && offsetLoadN |=> wrPtr == $past(wrPtr);
  endproperty
  a_fullBlocks: assert property (p_fullBlocks) // see R5
    else $error("write taken while full");

  property p_emptyHolds;
    !emptyN && !rdEnN && offsetLoadN && !wrAcc
      |=> rdPtr == $past(rdPtr) && rdData == $past(rdData);
  endproperty
  a_emptyHolds: assert property (p_emptyHolds) // see R8
    else $error("read changed state while empty");

  property p_idleHolds;
    rdEnN && !(isEmpty && wrAcc) |=> rdData == $past(rdData);
  endproperty
  a_idleHolds: assert property (p_idleHolds) // see R7
    else $error("output changed without a read");

  property p_fallThrough;
    isEmpty && wrAcc && rdEnN
      |=> rdData == $past(wrData) && emptyN;
  endproperty
  a_fallThrough: assert property (p_fallThrough) // see R25
    else $error("first word did not fall through");

  property p_fullFlag;
    fullN == (count != CNT_FULL);
  endproperty
  a_fullFlag: assert property (p_fullFlag) // see R15
    else $error("full flag disagrees with fill level");

  property p_emptyFlag;
    emptyN == (count != CNT_ZERO);
  endproperty
  a_emptyFlag: assert property (p_emptyFlag) // see R20
    else $error("empty flag disagrees with fill level");

  property p_resetState;
    disable iff (1'b0)
    srst |=> fullN && almostFullN && !emptyN && !almostEmptyN
             && wrPtr == PTR_ZERO && rdPtr == PTR_ZERO;
  endproperty
  a_resetState: assert property (p_resetState) // see R10
    else $error("reset left wrong flags or pointers");

  property p_outEnable;
    rdDataOe == !outEnN;
  endproperty
  a_outEnable: assert property (p_outEnable) // see R9
    else $error("output enable not followed");

  property p_loadNoStore;
    !offsetLoadN && !wrEnN |=> wrPtr == $past(wrPtr) && count == $past(count);
  endproperty
  a_loadNoStore: assert property (p_loadNoStore) // see R12
    else $error("load-mode write reached the array");

  property p_ofsRead;
    !offsetLoadN && !rdEnN
      |=> rdData[DATA_W-1:OFS_W] == '0 && rdData[OFS_W-1:0] == $past(ofsRdBits);
  endproperty
  a_ofsRead: assert property (p_ofsRead) // see R13
    else $error("offset readback wrong");

  property p_halfFull;
    !chainMode |-> halfFullN == (count <= CNT_HALF);
  endproperty
  a_halfFull: assert property (p_halfFull) // see R22
    else $error("half-full flag wrong");

  property p_rdChain;
    !rdChainOutN |-> chainMode && $past(rdLast);
  endproperty
  a_rdChain: assert property (p_rdChain) // see R23
    else $error("read chain pulse without last read");

  property p_countStep;
    wrAcc && !rdAcc |=> count == CNT_W'($past(count) + CNT_ONE);
  endproperty
  a_countStep: assert property (p_countStep) // see R4
    else $error("write did not add one word");

endmodule

// ==== tb/fcf_partner.sv ====
module fcf_partner
  import fcf_pkg::*;
(
  input  wire logic                       sys_clk,
  input  wire logic                       srst,
  input  wire logic                       doWr,
  input  wire logic                       doRd,
  input  wire logic                       doLoad,
  input  wire logic [fcf_pkg::DATA_W-1:0] word,
  output logic                            wrEnN,
  output logic                            rdEnN,
  output logic                            offsetLoadN,
  output logic      [fcf_pkg::DATA_W-1:0] wrData,
  output logic                            chainEnable,
  output logic                            chainFirstN,
  output logic                            wrChainInN,
  output logic                            rdChainInN
);
  timeunit 1ns;
  timeprecision 1ps;

  // Single device: straps grounded
  assign chainEnable = 1'b0;
  assign chainFirstN = 1'b0;
  assign wrChainInN  = 1'b0;
  assign rdChainInN  = 1'b0;

  initial begin
    wrEnN       = 1'b1;
    rdEnN       = 1'b1;
    offsetLoadN = 1'b1;
    wrData      = '0;
  end

  // No request while reset is held
  always @(posedge sys_clk) begin
    wrEnN       <= srst | !doWr;
    rdEnN       <= srst | !doRd;
    offsetLoadN <= srst | !doLoad;
    // Idle data wanders so a stray capture shows
    wrData      <= doWr ? word : DATA_W'($urandom);
  end
endmodule

// ==== tb/fcf_top_tb.sv ====
module fcf_top_tb;
  import fcf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int DEPTH = DEPTH_256;
  logic sys_clk = 0, srst = 1, outEnN = 0;
  logic doWr = 0, doRd = 0, doLoad = 0;
  logic [DATA_W-1:0] word = '0, rdData, wrData;
  logic wrEnN, rdEnN, offsetLoadN, chainEnable, chainFirstN;
  logic wrChainInN, rdChainInN, rdDataOe, fullN, emptyN;
  logic almostEmptyN, almostFullN, halfFullN, rdChainOutN;
  int nMismatch = 0, numChecks = 0, cyc = 0, cnt = 0, skip = 0;
  logic [DATA_W-1:0] expQ[$], holdV, pv;
  logic [OFS_W-1:0] ae, af;
  bit seq, pend, holdOk, rdOk, wrOk, rw;

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  fcf_partner pm_u (.sys_clk(sys_clk), .srst(srst), .doWr(doWr),
    .doRd(doRd), .doLoad(doLoad), .word(word), .wrEnN(wrEnN),
    .rdEnN(rdEnN), .offsetLoadN(offsetLoadN), .wrData(wrData),
    .chainEnable(chainEnable), .chainFirstN(chainFirstN),
    .wrChainInN(wrChainInN), .rdChainInN(rdChainInN));

  fcf_top #(.DEPTH(DEPTH)) dut_u (.sys_clk(sys_clk), .srst(srst),
    .wrData(wrData), .wrEnN(wrEnN), .rdEnN(rdEnN), .outEnN(outEnN),
    .offsetLoadN(offsetLoadN), .chainEnable(chainEnable),
    .chainFirstN(chainFirstN), .wrChainInN(wrChainInN),
    .rdChainInN(rdChainInN), .rdData(rdData), .rdDataOe(rdDataOe),
    .fullN(fullN), .emptyN(emptyN), .almostEmptyN(almostEmptyN),
    .almostFullN(almostFullN), .halfFullN(halfFullN),
    .rdChainOutN(rdChainOutN));

  task automatic summarize();
    $display("checks %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One request cycle; a noted word is expected at the head later
  task automatic step(input bit w, r, l, input logic [DATA_W-1:0] d,
                      input bit note);
    @(posedge sys_clk);
    doWr   <= w;
    doRd   <= r;
    doLoad <= l;
    word   <= d;
    outEnN <= 1'($urandom);
    if (note) expQ.push_back(d);
  endtask

  // Timeout: whole run is about nine hundred cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 4000) begin
      nMismatch++;
      summarize();
    end
  end

  // Monitor: flags from the occupancy model, head word from the queue
  always @(posedge sys_clk) begin
    if (srst) begin
      cnt = 0; expQ.delete(); ae = 12'h01F; af = 12'h01F;
      seq = 0; pend = 0; holdOk = 0; skip = 0;
    end else begin
      check("oe", rdDataOe, !outEnN);
      check("rchain", rdChainOutN, 1'b1);
      if (skip > 0) skip--;
      else begin
        check("full", fullN, cnt != DEPTH);
        check("empty", emptyN, cnt != 0);
        check("aempty", almostEmptyN, cnt > ae);
        check("afull", almostFullN, cnt < DEPTH - af);
        check("half", halfFullN, cnt <= DEPTH / 2);
      end
      if (pend) check("offset", rdData, {6'h00, pv});
      pend = 0;
      if (cnt == 0 && holdOk) check("hold", rdData, holdV);
      if (!offsetLoadN) begin
        holdOk = 0;
        if (!rdEnN) begin
          pend = 1;
          pv = seq ? af : ae;
        end
        if (!wrEnN && seq) af = wrData[OFS_W-1:0];
        if (!wrEnN && !seq) ae = wrData[OFS_W-1:0];
        if (!wrEnN || !rdEnN) seq = !seq;
        skip = 2;
      end else begin
        if (cnt > 0) check("head", rdData, expQ[0]);
        rdOk = !rdEnN && cnt > 0;
        wrOk = !wrEnN && cnt < DEPTH;
        if (rdOk) holdV = expQ.pop_front();
        cnt = cnt + int'(wrOk) - int'(rdOk);
        holdOk = (rdOk && cnt == 0) || (holdOk && !wrOk);
      end
    end
  end

  initial begin
    void'($urandom(32'h32CEFD6C));
    repeat (10) @(posedge sys_clk);
    srst <= 0;
    repeat (2) step(0, 0, 0, '0, 0);
    // Defaults, then program FC5/9, read back, then write+read together
    step(0, 1, 1, '0, 0);
    step(0, 1, 1, '0, 0);
    step(1, 0, 1, 18'h3FFC5, 0);
    step(1, 0, 1, 18'h00009, 0);
    step(0, 1, 1, '0, 0);
    step(0, 1, 1, '0, 0);
    step(1, 1, 1, 18'h00007, 0);
    repeat (3) step(0, 0, 0, '0, 0);
    // Fill to full, then two refused writes
    for (int i = 0; i < DEPTH; i++) begin
      if ($urandom % 4 == 0) step(0, 0, 0, '0, 0);
      step(1, 0, 0, DATA_W'($urandom), 1);
    end
    step(1, 0, 0, 18'h2AAAA, 0);
    step(1, 0, 0, 18'h15555, 0);
    // Drain past empty; last reads must be ignored
    for (int i = 0; i < DEPTH + 2; i++) begin
      if ($urandom % 4 == 0) step(0, 0, 0, '0, 0);
      step(0, 1, 0, '0, 0);
    end
    // Mixed traffic, reads and writes in the same cycle
    for (int i = 0; i < 200; i++) begin
      rw = 1'($urandom);
      step(rw, 1'($urandom), 0, DATA_W'($urandom), rw);
    end
    repeat (2) step(0, 0, 0, '0, 0);
    // Reset in mid-run with words still stored
    @(posedge sys_clk);
    srst <= 1;
    repeat (3) @(posedge sys_clk);
    srst <= 0;
    repeat (2) step(0, 0, 0, '0, 0);
    for (int i = 0; i < 3; i++) step(1, 0, 0, DATA_W'($urandom), 1);
    repeat (4) step(0, 1, 0, '0, 0);
    repeat (4) step(0, 0, 0, '0, 0);
    summarize();
  end
endmodule
